// File: imbd_defs.svh
// Constants for the indirect move and bank decode block
`ifndef IMBD_DEFS_SVH
`define IMBD_DEFS_SVH
`define IMBD_ADDR_CTRL      8'h00
`define IMBD_ADDR_INSTR     8'h04
`define IMBD_ADDR_ACC       8'h08
`define IMBD_ADDR_PTR0      8'h0C
`define IMBD_ADDR_PTR1      8'h10
`define IMBD_ADDR_BANK      8'h14
`define IMBD_ADDR_STATUS    8'h18
`define IMBD_ADDR_MEMADDR   8'h1C
`define IMBD_ADDR_MEMDATA   8'h20
`define IMBD_CTRL_GO_BIT    0
`define IMBD_STAT_BUSY_BIT  0
`define IMBD_STAT_ZERO_BIT  1
`define IMBD_INSTR_OP_LSB   24
`define IMBD_INSTR_DEST_BIT 7
`define IMBD_INSTR_PSEL_BIT 8
`define IMBD_INSTR_REL_BIT  9
`define IMBD_INSTR_MM_LSB   0
`define IMBD_INSTR_K_LSB    0
`define IMBD_FILE_ADDR_MAX  7'h7F
`define IMBD_BANK_MAX       5'h1F
`define IMBD_OFS_MIN        (-32)
`define IMBD_OFS_MAX        31
`define IMBD_WIN0_ADDR      16'h0000
`define IMBD_WIN1_ADDR      16'h0001
`define IMBD_RESP_OKAY      2'h0
`define IMBD_RESP_SLVERR    2'h2
`endif

// File: imbd_pkg.sv
// Types for the indirect move and bank decode block
package imbd_pkg;
  typedef enum logic [1:0] {
    IMBD_OP_NOP,
    IMBD_OP_DIRECT,
    IMBD_OP_INDIRECT,
    IMBD_OP_BANK
  } imbd_op_t;
  typedef enum logic [1:0] {
    IMBD_MM_PREINC,
    IMBD_MM_PREDEC,
    IMBD_MM_POSTINC,
    IMBD_MM_POSTDEC
  } imbd_mm_t;
  typedef enum {
    IMBD_ST_IDLE,
    IMBD_ST_READ,
    IMBD_ST_WRITE
  } imbd_state_t;
endpackage

// File: imbd_ptr_calc.sv
// Effective address and pointer update for an indirect load
`timescale 1ns/10ps
`include "imbd_defs.svh"
module imbd_ptr_calc #(
  parameter int PTR_W = 16
) (
  input  wire logic [PTR_W-1:0] ptr,
  input  wire logic [1:0]       mode,
  input  wire logic             relative,
  input  wire logic [5:0]       offset,
  output logic      [PTR_W-1:0] eff_addr,
  output logic      [PTR_W-1:0] ptr_next
);
  logic [PTR_W-1:0] plus1;
  logic [PTR_W-1:0] minus1;
  logic [PTR_W-1:0] ofs_ext;
  always_comb begin
    // Pointer wraps within 16 bits at the bounds
    plus1   = ptr + {{(PTR_W-1){1'b0}}, 1'b1};
    minus1  = ptr - {{(PTR_W-1){1'b0}}, 1'b1};
    ofs_ext = {{(PTR_W-6){offset[5]}}, offset};
    if (relative) begin
      eff_addr = ptr + ofs_ext;
      ptr_next = ptr;
    end else begin
      case (imbd_pkg::imbd_mm_t'(mode))
        imbd_pkg::IMBD_MM_PREINC: begin
          eff_addr = plus1;
          ptr_next = plus1;
        end
        imbd_pkg::IMBD_MM_PREDEC: begin
          eff_addr = minus1;
          ptr_next = minus1;
        end
        imbd_pkg::IMBD_MM_POSTINC: begin
          eff_addr = ptr;
          ptr_next = plus1;
        end
        default: begin
          eff_addr = ptr;
          ptr_next = minus1;
        end
      endcase
    end
  end
endmodule

// File: imbd_core.sv
// Data-move execution unit with AXI4-Lite register access
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "imbd_defs.svh"
module imbd_core #(
  parameter int MEM_WORDS = 256
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int AW = $clog2(MEM_WORDS);

  // No reset on data memory, software loads it first
  logic [7:0]  mem [MEM_WORDS];
  logic [31:0] instr_q;
  logic [31:0] instr_d;
  logic [7:0]  acc_q;
  logic [7:0]  acc_d;
  logic [15:0] ptr0_q;
  logic [15:0] ptr0_d;
  logic [15:0] ptr1_q;
  logic [15:0] ptr1_d;
  logic [4:0]  bank_q;
  logic [4:0]  bank_d;
  logic        zero_q;
  logic        zero_d;
  logic        busy_q;
  logic        busy_d;
  logic [15:0] maddr_q;
  logic [15:0] maddr_d;
  logic        aw_q;
  logic        aw_d;
  logic        w_q;
  logic        w_d;
  logic [31:0] awaddr_q;
  logic [31:0] awaddr_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic [3:0]  wstrb_q;
  logic [3:0]  wstrb_d;
  logic        bvalid_q;
  logic        bvalid_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  imbd_pkg::imbd_op_t op;
  logic [15:0] eff_addr;
  logic [15:0] ptr_next;
  logic [15:0] sel_ptr;
  logic [15:0] exec_addr;
  logic [15:0] bus_addr;
  logic [7:0]  exec_val;
  logic        exec_wr;
  logic        bus_mem_wr;
  logic        do_write;
  logic        do_read;

  assign op = imbd_pkg::imbd_op_t'(instr_q[`IMBD_INSTR_OP_LSB +: 2]);
  assign sel_ptr = instr_q[`IMBD_INSTR_PSEL_BIT] ? ptr1_q : ptr0_q;

  imbd_ptr_calc #(
    .PTR_W    (16)
  ) u_ptr (
    .ptr      (sel_ptr),
    .mode     (instr_q[`IMBD_INSTR_MM_LSB +: 2]),
    .relative (instr_q[`IMBD_INSTR_REL_BIT]),
    .offset   (instr_q[`IMBD_INSTR_K_LSB +: 6]),
    .eff_addr (eff_addr),
    .ptr_next (ptr_next)
  );

  // Window addresses hold no data, they redirect
  function automatic logic [15:0] resolve(input logic [15:0] a,
                                          input logic [15:0] p0,
                                          input logic [15:0] p1);
    if (a == `IMBD_WIN0_ADDR) begin
      resolve = p0;
    end else if (a == `IMBD_WIN1_ADDR) begin
      resolve = p1;
    end else begin
      resolve = a;
    end
  endfunction

  always_comb begin
    exec_addr = 16'h0000;
    if (op == imbd_pkg::IMBD_OP_DIRECT) begin
      exec_addr = resolve({9'h0, instr_q[6:0]}, ptr0_q, ptr1_q);
    end else begin
      exec_addr = resolve(eff_addr, ptr0_q, ptr1_q);
    end
    exec_val = mem[exec_addr[AW-1:0]];
    exec_wr  = busy_q && (op == imbd_pkg::IMBD_OP_DIRECT) &&
               instr_q[`IMBD_INSTR_DEST_BIT];
    bus_addr = resolve(maddr_q, ptr0_q, ptr1_q);
  end

  // Memory port, execution takes priority over bus write
  always_ff @(posedge aclk) begin
    if (clk_en) begin
      if (exec_wr) begin
        mem[exec_addr[AW-1:0]] <= exec_val;
      end else if (bus_mem_wr) begin
        mem[bus_addr[AW-1:0]] <= wdata_q[7:0];
      end
    end
  end

  always_comb begin
    do_write = aw_q && w_q && !bvalid_q;
    do_read  = s_axi_arvalid && !rvalid_q;
    aw_d = aw_q;
    w_d = w_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    instr_d = instr_q;
    acc_d = acc_q;
    ptr0_d = ptr0_q;
    ptr1_d = ptr1_q;
    bank_d = bank_q;
    zero_d = zero_q;
    busy_d = 1'b0;
    maddr_d = maddr_q;
    bus_mem_wr = 1'b0;
    if (s_axi_awvalid && !aw_q) begin
      aw_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q) begin
      w_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (s_axi_bready && bvalid_q) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_rready && rvalid_q) begin
      rvalid_d = 1'b0;
    end
    // Execute the latched instruction for one cycle
    if (busy_q) begin
      case (op)
        imbd_pkg::IMBD_OP_DIRECT: begin
          if (!instr_q[`IMBD_INSTR_DEST_BIT]) begin
            acc_d = exec_val;
          end
          zero_d = (exec_val == 8'h00);
        end
        imbd_pkg::IMBD_OP_INDIRECT: begin
          acc_d  = exec_val;
          zero_d = (exec_val == 8'h00);
          if (instr_q[`IMBD_INSTR_PSEL_BIT]) begin
            ptr1_d = ptr_next;
          end else begin
            ptr0_d = ptr_next;
          end
        end
        imbd_pkg::IMBD_OP_BANK: begin
          // Zero flag left alone on bank load, busy clears as after any op
          bank_d = instr_q[`IMBD_INSTR_K_LSB +: 5];
        end
        default: begin
        end
      endcase
    end
    if (do_write) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `IMBD_RESP_OKAY;
      // Writes during execution are refused with an error
      if (busy_q) begin
        bresp_d = `IMBD_RESP_SLVERR;
      end else begin
        case (awaddr_q[7:0])
          8'(`IMBD_ADDR_CTRL):
            busy_d = wdata_q[`IMBD_CTRL_GO_BIT] && wstrb_q[0];
          8'(`IMBD_ADDR_INSTR): instr_d = wdata_q;
          8'(`IMBD_ADDR_ACC): acc_d = wdata_q[7:0];
          8'(`IMBD_ADDR_PTR0): ptr0_d = wdata_q[15:0];
          8'(`IMBD_ADDR_PTR1): ptr1_d = wdata_q[15:0];
          8'(`IMBD_ADDR_BANK): bank_d = wdata_q[4:0];
          8'(`IMBD_ADDR_MEMADDR): maddr_d = wdata_q[15:0];
          8'(`IMBD_ADDR_MEMDATA): bus_mem_wr = 1'b1;
          default: bresp_d = `IMBD_RESP_SLVERR;
        endcase
      end
    end
    if (do_read) begin
      rvalid_d = 1'b1;
      rresp_d = `IMBD_RESP_OKAY;
      rdata_d = 32'h0000_0000;
      case (s_axi_araddr[7:0])
        8'(`IMBD_ADDR_CTRL): rdata_d = 32'h0000_0000;
        8'(`IMBD_ADDR_INSTR): rdata_d = instr_q;
        8'(`IMBD_ADDR_ACC): rdata_d = {24'h000000, acc_q};
        8'(`IMBD_ADDR_PTR0): rdata_d = {16'h0000, ptr0_q};
        8'(`IMBD_ADDR_PTR1): rdata_d = {16'h0000, ptr1_q};
        8'(`IMBD_ADDR_BANK): rdata_d = {27'h0, bank_q};
        8'(`IMBD_ADDR_STATUS):
          rdata_d = {30'h0, zero_q, busy_q};
        8'(`IMBD_ADDR_MEMADDR): rdata_d = {16'h0000, maddr_q};
        8'(`IMBD_ADDR_MEMDATA):
          rdata_d = {24'h000000, mem[bus_addr[AW-1:0]]};
        default: rresp_d = `IMBD_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
      instr_q <= 32'h0000_0000;
      acc_q <= 8'h00;
      ptr0_q <= 16'h0000;
      ptr1_q <= 16'h0000;
      bank_q <= 5'h00;
      zero_q <= 1'b0;
      busy_q <= 1'b0;
      maddr_q <= 16'h0000;
    end else if (clk_en) begin
      aw_q <= aw_d;
      w_q <= w_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      instr_q <= instr_d;
      acc_q <= acc_d;
      ptr0_q <= ptr0_d;
      ptr1_q <= ptr1_d;
      bank_q <= bank_d;
      zero_q <= zero_d;
      busy_q <= busy_d;
      maddr_q <= maddr_d;
    end
  end

  // Ready only while the holding slot is empty
  assign s_axi_awready = clk_en && !aw_q;
  assign s_axi_wready  = clk_en && !w_q;
  assign s_axi_arready = clk_en && !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
endmodule

// File: imbd_checker.sv
// Bus handshake checker for the data-move unit
`timescale 1ns/10ps
module imbd_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  wr_answer_a: assert property (wr_take |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (b_wait |=> s_axi_bvalid)
    else $error("write response dropped early");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  en_freeze_a: assert property (!clk_en |-> !(s_axi_awready || s_axi_arready))
    else $error("ready while clock enable low");
  rst_quiet_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid)
    else $error("response pending after reset");
endmodule
bind imbd_core imbd_checker u_chk (.aclk, .aresetn, .clk_en, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

// File: testbench.sv
// Self-checking bench for the data-move unit
`timescale 1ns/10ps
`include "imbd_defs.svh"
module testbench;
  logic        aclk, aresetn = 1'b0, clk_en = 1'b1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [1:0]  bresp, rresp;
  logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, awr, wrr, bv, arr, rv;
  logic [7:0]  v;
  logic [6:0]  f;
  logic [15:0] p;
  int          fails = 0, checked = 0, seed = 32'hb56801dd;
  imbd_core DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(1'b1));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= {24'h0, a};
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    // Each channel released on its own handshake
    while (pa || pw) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (awr) pa = 1'b0;
      if (wrr) wv <= 1'b0;
      if (wrr) pw = 1'b0;
    end
    do @(posedge aclk); while (!bv);
    chk(32'(bresp), 32'(er));
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = 2'h0);
    araddr <= {24'h0, a};
    arv <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    do @(posedge aclk); while (!rv);
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
  endtask
  task automatic ex(input logic [31:0] i);
    wr(`IMBD_ADDR_INSTR, i);
    wr(`IMBD_ADDR_CTRL, 32'h1);
    // Results land one edge after the go response
    repeat (2) @(posedge aclk);
  endtask
  task automatic mw(input logic [15:0] a, input logic [7:0] d);
    wr(`IMBD_ADDR_MEMADDR, 32'(a));
    wr(`IMBD_ADDR_MEMDATA, 32'(d));
  endtask
  function automatic logic [15:0] nxt(logic [15:0] q, logic [5:0] k, logic r);
    return r ? q : k[0] ? q - 16'h1 : q + 16'h1;
  endfunction
  task automatic ind(input logic n, input logic r, input logic [5:0] k,
                     input logic [15:0] q);
    logic [15:0] e;
    logic [7:0]  pa;
    pa = n ? `IMBD_ADDR_PTR1 : `IMBD_ADDR_PTR0;
    e = r ? q + {{10{k[5]}}, k} : k[1] ? q : nxt(q, k, r);
    v = 8'($random(seed));
    wr(pa, 32'(q));
    mw(e, v);
    ex({8'h02, 14'h0, r, n, 2'h0, k});
    rc(`IMBD_ADDR_ACC, 32'(v));
    rc(pa, 32'(nxt(q, k, r)));
  endtask
  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    clk_en <= 1'b0;
    repeat (3) @(posedge aclk);
    clk_en <= 1'b1;
    rc(`IMBD_ADDR_STATUS, 32'h0);
    rc(`IMBD_ADDR_BANK, 32'h0);
    rc(8'h24, 32'h0, `IMBD_RESP_SLVERR);
    wr(8'h24, 32'h0, `IMBD_RESP_SLVERR);
    wr(`IMBD_ADDR_STATUS, 32'h3, `IMBD_RESP_SLVERR);
    rc(`IMBD_ADDR_STATUS, 32'h0);
    for (int i = 0; i < 6; i++) begin
      f = i == 0 ? 7'h7F : 7'($random(seed)) | 7'h2;
      v = i == 1 ? 8'h0 : 8'($random(seed));
      wr(`IMBD_ADDR_ACC, {24'h0, ~v});
      mw(16'(f), v);
      ex({8'h01, 16'h0, i[0], f});
      rc(`IMBD_ADDR_ACC, {24'h0, i[0] ? ~v : v});
      rc(`IMBD_ADDR_MEMDATA, 32'(v));
      rc(`IMBD_ADDR_STATUS, {30'h0, v == 8'h0, 1'b0});
    end
    p = 16'h0055;
    v = 8'($random(seed)) | 8'h1;
    wr(`IMBD_ADDR_PTR1, 32'(p));
    mw(p, v);
    ex({8'h01, 24'h000001});
    rc(`IMBD_ADDR_ACC, 32'(v));
    // Zero flag set so that the bank load must keep it
    mw(16'h0070, 8'h00);
    ex({8'h01, 24'h000070});
    rc(`IMBD_ADDR_STATUS, 32'h2);
    for (int i = 0; i < 4; i++) begin
      f = i == 0 ? 7'h1F : 7'($random(seed)) & 7'h1F;
      ex({8'h03, 19'h0, f[4:0]});
      rc(`IMBD_ADDR_BANK, 32'(f));
      rc(`IMBD_ADDR_STATUS, 32'h2);
    end
    for (int i = 0; i < 12; i++) begin
      p = 16'h0060 | 16'(6'($random(seed)));
      if (i < 8)
        ind(i[0], 1'b0, 6'(i[2:1]), p);
      else
        ind(i[0], 1'b1, i == 8 ? 6'h20 : 6'h1F, p);
    end
    ind(1'b1, 1'b0, 6'h2, 16'hFFFF);
    ind(1'b0, 1'b0, 6'h1, 16'h0);
    test_done();
  end
endmodule
